// *** core/ssr_defs.vh ***
// constants of the serial/parallel shift register block
// assumes inclusion by bare name from files under core/
//
// Operation
// - first stage input is data AND enable
// - shift edge captures data while enable high
// - every stage passes value to next stage
// - first stage value reaches last after seven
// - master clear empties the whole chain
// - chain holds eight bits, one per stage
// - own shift clock advances serial-parallel chain
// - storage edge copies chain into output register
// - storage edge captures parallel word into input
// - load low plus storage edge loads directly
// - load low without edge takes input register
// - shift edge moves stages, serial in first
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH

// ----------------------------------------------------------------
// widths and depths
// ----------------------------------------------------------------
`define SSR_WIDTH        8
`define SSR_FIFO_DEPTH   8
`define SSR_FIFO_AW      3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSR_CHAIN_RST    8'h00
`define SSR_BIT_RST      1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSR_CLK_PERIOD_NS   20
`define SSR_MIN_PULSE_NS    40
`define SSR_MIN_PULSE_CYC   ((`SSR_MIN_PULSE_NS + `SSR_CLK_PERIOD_NS - 1) / `SSR_CLK_PERIOD_NS)

`endif

// *** core/ssr_fifo.v ***
// word fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module ssr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             ref_clk,
    input  wire             srst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_r;
    reg  [AW-1:0]    rd_ptr_r;
    reg  [AW:0]      count_r;
    wire             push;
    wire             pop;

    // honest full and empty from the word count
    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage array, written only on accepted words
    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap at depth, count tracks occupancy
    always @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
                            {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
                            {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule // ssr_fifo

// *** core/ssr_top.v ***
// three shift register functions sharing one system clock:
//   a: gated serial-in chain with master clear
//   b: serial-to-parallel chain with storage register and word fifo
//   c: parallel-to-serial chain with input register and load
// assumes pin inputs other than srst and s2p_word_ready are asynchronous to ref_clk; pin clocks are
// sampled and their rising edges detected, so each pin level must
// stand for at least SSR_MIN_PULSE_CYC system clocks
//
// latency: a pin change acts on the third ref_clk edge after it,
// two edges of synchroniser and one of register update
// after srst the load pin reads low until its synchroniser fills,
// so variant c copies the cleared input register for two cycles
// master_clear acts on variant a only; variants b and c ignore it
`timescale 1ns/1ps
`include "ssr_defs.vh"

module ssr_top #(
    parameter WIDTH      = `SSR_WIDTH,
    parameter FIFO_DEPTH = `SSR_FIFO_DEPTH,
    parameter FIFO_AW    = `SSR_FIFO_AW
) (
    input  wire             ref_clk,
    input  wire             srst,
    // variant a pins
    input  wire             serial_data_in_a,
    input  wire             serial_enable_in,
    input  wire             shift_clock,
    input  wire             master_clear,
    output wire [WIDTH-1:0] stage_out,
    output wire             first_stage_out,
    output wire             last_stage_out,
    // variant b pins
    input  wire             s2p_serial_data_in,
    input  wire             s2p_shift_reg_clock,
    input  wire             s2p_storage_reg_clock,
    output wire [WIDTH-1:0] s2p_stage_out,
    output wire [WIDTH-1:0] s2p_word_out,
    output wire             s2p_word_valid,
    input  wire             s2p_word_ready,
    output wire             s2p_fifo_ready,
    output wire             s2p_overflow,
    // variant c pins
    input  wire             serial_data_in,
    input  wire             shift_reg_clock,
    input  wire             storage_reg_clock,
    input  wire             parallel_load_n,
    input  wire [WIDTH-1:0] p2s_par_in,
    output wire             p2s_serial_out,
    output wire [WIDTH-1:0] p2s_input_word
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // single-bit pins other than srst and s2p_word_ready share one vector; the parallel word has its own
    localparam NPIN = 10;

    wire [NPIN-1:0]  pin_raw;
    reg  [NPIN-1:0]  pin_meta_r;
    reg  [NPIN-1:0]  pin_sync_r;
    reg  [NPIN-1:0]  pin_prev_r;
    reg  [WIDTH-1:0] par_meta_r;
    reg  [WIDTH-1:0] par_sync_r;

    assign pin_raw = {parallel_load_n, storage_reg_clock, shift_reg_clock,
                      serial_data_in, s2p_storage_reg_clock,
                      s2p_shift_reg_clock, s2p_serial_data_in,
                      master_clear, shift_clock,
                      serial_data_in_a & serial_enable_in};

    // two flops per pin; the first is read only by the second
    always @(posedge ref_clk) begin
        if (srst) begin
            pin_meta_r <= {NPIN{1'b0}};
            pin_sync_r <= {NPIN{1'b0}};
            par_meta_r <= `SSR_CHAIN_RST;
            par_sync_r <= `SSR_CHAIN_RST;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
            par_meta_r <= p2s_par_in;
            par_sync_r <= par_meta_r;
        end
    end

    // previous synced level, for rising edge detection
    always @(posedge ref_clk) begin
        if (srst) begin
            pin_prev_r <= {NPIN{1'b0}};
        end else begin
            pin_prev_r <= pin_sync_r;
        end
    end

    // ----------------------------------------------------------------
    // decoded pin levels and edges
    // ----------------------------------------------------------------
    wire a_gated_in;
    wire a_shift_rise;
    wire a_clear;
    wire b_data;
    wire b_shift_rise;
    wire b_store_rise;
    wire c_data;
    wire c_shift_rise;
    wire c_store_rise;
    wire c_load_low;

    // rising edges compare the synced level with its previous copy
    assign a_gated_in   = pin_sync_r[0];
    assign a_shift_rise = pin_sync_r[1] & ~pin_prev_r[1];
    assign a_clear      = pin_sync_r[2];
    assign b_data       = pin_sync_r[3];
    assign b_shift_rise = pin_sync_r[4] & ~pin_prev_r[4];
    assign b_store_rise = pin_sync_r[5] & ~pin_prev_r[5];
    assign c_data       = pin_sync_r[6];
    assign c_shift_rise = pin_sync_r[7] & ~pin_prev_r[7];
    assign c_store_rise = pin_sync_r[8] & ~pin_prev_r[8];
    assign c_load_low   = ~pin_sync_r[9];

    // ----------------------------------------------------------------
    // variant a: gated serial-in chain
    // ----------------------------------------------------------------
    // eight stages, bit 0 is the first
    reg  [WIDTH-1:0] a_chain_r;
    wire [WIDTH-1:0] a_chain_nxt;

    // per-stage next value: stage 0 takes the gated input, the rest
    // take their neighbour, all on the same shift edge
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_a_stage
            if (gi == 0) begin : g_first
                assign a_chain_nxt[gi] = a_gated_in;
            end else begin : g_next
                assign a_chain_nxt[gi] = a_chain_r[gi-1];
            end
        end
    endgenerate

    // clear dominates the shift edge
    always @(posedge ref_clk) begin
        if (srst) begin
            a_chain_r <= `SSR_CHAIN_RST;
        end else if (a_clear) begin
            a_chain_r <= `SSR_CHAIN_RST;
        end else if (a_shift_rise) begin
            a_chain_r <= a_chain_nxt;
        end
    end

    // end outputs straight from the chain flops
    assign stage_out       = a_chain_r;
    assign first_stage_out = a_chain_r[0];
    assign last_stage_out  = a_chain_r[WIDTH-1];

    // ----------------------------------------------------------------
    // variant b: serial-to-parallel chain and storage register
    // ----------------------------------------------------------------
    reg  [WIDTH-1:0] b_chain_r;
    reg  [WIDTH-1:0] b_store_r;
    reg              b_push_r;

    // the chain moves only on its own shift clock
    always @(posedge ref_clk) begin
        if (srst) begin
            b_chain_r <= `SSR_CHAIN_RST;
        end else if (b_shift_rise) begin
            b_chain_r <= {b_chain_r[WIDTH-2:0], b_data};
        end
    end

    // the storage edge snapshots the chain as it stands; the chain's
    // own update in the same cycle is not seen, as on the pins
    always @(posedge ref_clk) begin
        if (srst) begin
            b_store_r <= `SSR_CHAIN_RST;
            b_push_r  <= 1'b0;
        end else begin
            b_push_r <= b_store_rise;
            if (b_store_rise) begin
                b_store_r <= b_chain_r;
            end
        end
    end

    // chain contents shown on the pins
    assign s2p_stage_out = b_chain_r;

    // ----------------------------------------------------------------
    // variant b: word fifo behind the storage register
    // ----------------------------------------------------------------
    // words leave the storage register one cycle after the storage
    // edge; a full fifo drops the word and raises the sticky flag
    wire             fifo_in_ready;
    wire             fifo_out_valid;
    wire [WIDTH-1:0] fifo_out_data;
    wire             fifo_pop;
    reg              word_valid_r;
    reg  [WIDTH-1:0] word_data_r;
    reg              fifo_ready_r;
    reg              overflow_r;

    // eight-word buffer between storage register and consumer
    ssr_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_valid  (b_push_r),
        .in_ready  (fifo_in_ready),
        .in_data   (b_store_r),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // output stage refills when empty or when its word is taken
    assign fifo_pop = fifo_out_valid & (~word_valid_r | s2p_word_ready);

    always @(posedge ref_clk) begin
        if (srst) begin
            word_valid_r <= 1'b0;
            word_data_r  <= `SSR_CHAIN_RST;
        end else if (fifo_pop) begin
            word_valid_r <= 1'b1;
            word_data_r  <= fifo_out_data;
        end else if (s2p_word_ready) begin
            word_valid_r <= 1'b0;
        end
    end

    // back-pressure to the controller, and a sticky lost-word flag
    // that only reset clears
    always @(posedge ref_clk) begin
        if (srst) begin
            fifo_ready_r <= 1'b0;
            overflow_r   <= 1'b0;
        end else begin
            fifo_ready_r <= fifo_in_ready;
            if (b_push_r & ~fifo_in_ready) begin
                overflow_r <= 1'b1;
            end
        end
    end

    // consumer side outputs, all registered
    assign s2p_word_out   = word_data_r;
    assign s2p_word_valid = word_valid_r;
    assign s2p_fifo_ready = fifo_ready_r;
    assign s2p_overflow   = overflow_r;

    // ----------------------------------------------------------------
    // variant c: input register
    // ----------------------------------------------------------------
    reg  [WIDTH-1:0] c_input_r;

    // storage edge captures the synced parallel pins
    always @(posedge ref_clk) begin
        if (srst) begin
            c_input_r <= `SSR_CHAIN_RST;
        end else if (c_store_rise) begin
            c_input_r <= par_sync_r;
        end
    end

    // held word visible to the controller
    assign p2s_input_word = c_input_r;

    // ----------------------------------------------------------------
    // variant c: loadable shift chain
    // ----------------------------------------------------------------
    // loadable chain; load low beats shift
    reg  [WIDTH-1:0] c_chain_r;
    reg  [WIDTH-1:0] c_chain_nxt;

    // load low overrides shifting; a storage edge during load passes
    // the pin word straight through, otherwise the held word is taken
    always @* begin
        c_chain_nxt = c_chain_r;
        if (c_load_low) begin
            if (c_store_rise) begin
                c_chain_nxt = par_sync_r;
            end else begin
                c_chain_nxt = c_input_r;
            end
        end else if (c_shift_rise) begin
            c_chain_nxt = {c_chain_r[WIDTH-2:0], c_data};
        end
    end

    // chain register takes its next value on every edge
    always @(posedge ref_clk) begin
        if (srst) begin
            c_chain_r <= `SSR_CHAIN_RST;
        end else begin
            c_chain_r <= c_chain_nxt;
        end
    end

    // last stage is the serial output
    assign p2s_serial_out = c_chain_r[WIDTH-1];

endmodule // ssr_top

// *** verif/ssr_ctrl_model.sv ***
// controller model shifting whole words into the s2p pins
// assumes the bench raises go and polls busy until it falls
`timescale 1ns/1ps

module ssr_ctrl_model (
    input  wire       ref_clk,
    input  wire       go,
    input  wire [7:0] word,
    output reg        sdat,
    output reg        sclk,
    output reg        stclk,
    output reg        busy
);
    integer i;

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    initial begin
        sdat = 1'b0;
        sclk = 1'b0;
        stclk = 1'b0;
        busy = 1'b0;
    end

    // msb first so bit 0 ends in the first stage; clock idle between frames
    always @(posedge go) begin
        busy = 1'b1;
        for (i = 7; i >= 0; i = i - 1) begin
            @(negedge ref_clk) sdat = word[i];
            repeat (3) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (3) @(negedge ref_clk);
            sclk = 1'b0;
            repeat (2) @(negedge ref_clk);
        end
        stclk = 1'b1;
        repeat (3) @(negedge ref_clk);
        stclk = 1'b0;
        sdat = ~sdat; // released line shows no stale bit
        repeat (8) @(negedge ref_clk);
        busy = 1'b0;
    end
endmodule // ssr_ctrl_model

// *** verif/ssr_top_props.sv ***
// assertions on the pins of the shift register block
// assumes bind onto ssr_top, one ref_clk domain, srst active high
`timescale 1ns/1ps

module ssr_top_props #(
    parameter WIDTH = 8
) (
    input wire             ref_clk,
    input wire             srst,
    input wire             serial_data_in_a,
    input wire             serial_enable_in,
    input wire             shift_clock,
    input wire             master_clear,
    input wire [WIDTH-1:0] stage_out,
    input wire             first_stage_out,
    input wire             last_stage_out,
    input wire             s2p_serial_data_in,
    input wire             s2p_shift_reg_clock,
    input wire             s2p_storage_reg_clock,
    input wire [WIDTH-1:0] s2p_stage_out,
    input wire [WIDTH-1:0] s2p_word_out,
    input wire             s2p_word_valid,
    input wire             s2p_word_ready,
    input wire             s2p_overflow,
    input wire             storage_reg_clock,
    input wire             parallel_load_n,
    input wire [WIDTH-1:0] p2s_par_in,
    input wire             p2s_serial_out,
    input wire [WIDTH-1:0] p2s_input_word
);
    // ----------------------------------------
    // pin edges act three clocks later
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_gate_first: assert property (
        $rose(shift_clock) && !master_clear |-> ##3
        first_stage_out == $past(serial_data_in_a & serial_enable_in, 3))
        else $error("first stage mismatch");
    a_chain_shift: assert property (
        $rose(shift_clock) && !master_clear |-> ##3
        stage_out[WIDTH-1:1] == $past(stage_out[WIDTH-2:0]))
        else $error("chain shift mismatch");
    a_clear_all: assert property (
        $rose(master_clear) |-> ##3 stage_out == 8'h00)
        else $error("clear left bits");
    a_ends_tied: assert property (
        first_stage_out == stage_out[0] &&
        last_stage_out == stage_out[WIDTH-1])
        else $error("end outputs differ from chain");
    a_s2p_shift: assert property (
        $rose(s2p_shift_reg_clock) |-> ##3 s2p_stage_out ==
        {$past(s2p_stage_out[WIDTH-2:0]), $past(s2p_serial_data_in, 3)})
        else $error("s2p chain mismatch");
    a_store_push: assert property (
        $rose(s2p_storage_reg_clock) && !s2p_word_valid
        |-> ##[3:8] s2p_word_valid)
        else $error("stored word not offered");
    a_word_hold: assert property (
        s2p_word_valid && !s2p_word_ready
        |=> s2p_word_valid && $stable(s2p_word_out))
        else $error("word dropped before taken");
    a_input_cap: assert property (
        $rose(storage_reg_clock) |-> ##3
        p2s_input_word == $past(p2s_par_in, 3))
        else $error("input register mismatch");
    a_load_copy: assert property (
        (!parallel_load_n)[*5] |->
        p2s_serial_out == p2s_input_word[WIDTH-1])
        else $error("load did not copy input word");
    a_direct_load: assert property (
        $rose(storage_reg_clock) && !parallel_load_n |-> ##3
        p2s_serial_out == $past(p2s_par_in[WIDTH-1], 3))
        else $error("direct load missed parallel word");

    // main scenarios seen
    c_shift: cover property ($rose(shift_clock) && serial_enable_in);
    c_overflow: cover property ($rose(s2p_overflow));
    c_load: cover property ($fell(parallel_load_n));
endmodule // ssr_top_props

bind ssr_top ssr_top_props #(.WIDTH(WIDTH)) i_ssr_top_props (
    .ref_clk(ref_clk), .srst(srst), .serial_data_in_a(serial_data_in_a),
    .serial_enable_in(serial_enable_in), .shift_clock(shift_clock),
    .master_clear(master_clear), .stage_out(stage_out),
    .first_stage_out(first_stage_out), .last_stage_out(last_stage_out),
    .s2p_serial_data_in(s2p_serial_data_in),
    .s2p_shift_reg_clock(s2p_shift_reg_clock),
    .s2p_storage_reg_clock(s2p_storage_reg_clock),
    .s2p_stage_out(s2p_stage_out), .s2p_word_out(s2p_word_out),
    .s2p_word_valid(s2p_word_valid), .s2p_word_ready(s2p_word_ready),
    .s2p_overflow(s2p_overflow), .storage_reg_clock(storage_reg_clock),
    .parallel_load_n(parallel_load_n), .p2s_par_in(p2s_par_in),
    .p2s_serial_out(p2s_serial_out), .p2s_input_word(p2s_input_word));

// *** verif/ssr_top_test.sv ***
// self-checking bench for the three shift register variants
// assumes ssr_top under core/ and the controller model beside it
`timescale 1ns/1ps

module ssr_top_test;
    logic       ref_clk = 1'b0;
    logic       srst = 1'b1;
    logic       sda = 1'b0;
    logic       sen = 1'b0;
    logic       shift_clock = 1'b0;
    logic       master_clear = 1'b0;
    logic       s2p_word_ready = 1'b0;
    logic       serial_data_in = 1'b0;
    logic       shift_reg_clock = 1'b0;
    logic       storage_reg_clock = 1'b0;
    logic       parallel_load_n = 1'b1;
    logic [7:0] p2s_par_in = 8'h00;
    logic [7:0] tx_word = 8'h00;
    logic       go = 1'b0;
    wire        sdat, sclk, stclk, busy, first_o, last_o, serial_o;
    wire        word_valid, fifo_ready, overflow;
    wire  [7:0] stage_out, s2p_stage_out, word_out, input_word;
    int         error_cnt = 0;
    int         num_checks = 0;

    // ----------------------------------------
    // clock, block and far side
    // ----------------------------------------
    always #10 ref_clk = ~ref_clk;

    ssr_top i_ssr_top (.ref_clk(ref_clk), .srst(srst),
        .serial_data_in_a(sda), .serial_enable_in(sen),
        .shift_clock(shift_clock), .master_clear(master_clear),
        .stage_out(stage_out), .first_stage_out(first_o),
        .last_stage_out(last_o), .s2p_serial_data_in(sdat),
        .s2p_shift_reg_clock(sclk), .s2p_storage_reg_clock(stclk),
        .s2p_stage_out(s2p_stage_out), .s2p_word_out(word_out),
        .s2p_word_valid(word_valid), .s2p_word_ready(s2p_word_ready),
        .s2p_fifo_ready(fifo_ready), .s2p_overflow(overflow),
        .serial_data_in(serial_data_in), .shift_reg_clock(shift_reg_clock),
        .storage_reg_clock(storage_reg_clock),
        .parallel_load_n(parallel_load_n), .p2s_par_in(p2s_par_in),
        .p2s_serial_out(serial_o), .p2s_input_word(input_word));

    ssr_ctrl_model i_ssr_ctrl_model (.ref_clk(ref_clk), .go(go),
        .word(tx_word), .sdat(sdat), .sclk(sclk), .stclk(stclk),
        .busy(busy));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task finish_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one pin clock pulse, long enough to pass the synchronisers
    task pulse(input int sel);
        cyc(3);
        case (sel)
            0: shift_clock = 1'b1;
            1: storage_reg_clock = 1'b1;
            default: shift_reg_clock = 1'b1;
        endcase
        cyc(3);
        shift_clock = 1'b0;
        storage_reg_clock = 1'b0;
        shift_reg_clock = 1'b0;
        cyc(4);
    endtask

    task send(input logic [7:0] w);
        int n;
        tx_word = w;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        for (n = 0; n < 200 && busy; n++) @(posedge ref_clk);
        cyc(1);
        if (busy) begin
            error_cnt++;
            $display("ERROR busy expected 0 seen %b", busy);
            finish_test;
        end
    endtask

    task pop(input logic [7:0] w);
        int n;
        for (n = 0; n < 50 && word_valid !== 1'b1; n++) cyc(1);
        if (word_valid !== 1'b1) begin
            error_cnt++;
            $display("ERROR word valid expected 1 seen %b", word_valid);
            finish_test;
        end
        chk("word out", w, word_out);
        s2p_word_ready = 1'b1;
        cyc(1);
        s2p_word_ready = 1'b0;
        cyc(3);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_serial_a;
        int k;
        sda = 1'b1;
        pulse(0);
        chk("gated chain", 8'h00, stage_out);
        sen = 1'b1;
        pulse(0);
        chk("first stage", 8'h01, stage_out);
        chk("first out", 8'h01, {7'h00, first_o});
        sda = 1'b0;
        for (k = 0; k < 7; k++) pulse(0);
        chk("after seven", 8'h80, stage_out);
        chk("last out", 8'h01, {7'h00, last_o});
        chk("first out", 8'h00, {7'h00, first_o});
        master_clear = 1'b1;
        cyc(4);
        master_clear = 1'b0;
        cyc(3);
        chk("cleared", 8'h00, stage_out);
    endtask

    task t_ser_par;
        int k;
        send(8'ha5);
        chk("s2p chain", 8'ha5, s2p_stage_out);
        pop(8'ha5);
        // output stage plus eight fifo words fill the path
        for (k = 0; k < 9; k++) send(8'h10 + k[7:0]);
        chk("fifo ready", 8'h00, {7'h00, fifo_ready});
        chk("overflow", 8'h00, {7'h00, overflow});
        send(8'h55);
        chk("overflow", 8'h01, {7'h00, overflow});
        for (k = 0; k < 9; k++) pop(8'h10 + k[7:0]);
        chk("drained", 8'h00, {7'h00, word_valid});
    endtask

    task t_par_ser;
        int k;
        p2s_par_in = 8'h96;
        pulse(1);
        chk("input word", 8'h96, input_word);
        chk("not loaded", 8'h00, {7'h00, serial_o});
        parallel_load_n = 1'b0;
        cyc(5);
        chk("loaded", 8'h01, {7'h00, serial_o});
        parallel_load_n = 1'b1;
        serial_data_in = 1'b1;
        for (k = 6; k >= 0; k--) begin
            pulse(2);
            chk("serial out", {7'h00, p2s_par_in[k]}, {7'h00, serial_o});
        end
        pulse(2);
        chk("serial in", 8'h01, {7'h00, serial_o});
        p2s_par_in = 8'h3c;
        parallel_load_n = 1'b0;
        pulse(1);
        chk("direct load", 8'h00, {7'h00, serial_o});
        chk("input word", 8'h3c, input_word);
        parallel_load_n = 1'b1;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cyc(2);
        srst = 1'b0;
        chk("reset chain", 8'h00, stage_out);
        chk("reset valid", 8'h00, {7'h00, word_valid});
        cyc(3);
        chk("fifo ready", 8'h01, {7'h00, fifo_ready});
        t_serial_a;
        t_ser_par;
        t_par_ser;
        finish_test;
    end
endmodule // ssr_top_test
